/* File: core/paes_pkg.sv */
// package for the packet and audio event status bank
// Notes on behaviour
// - status bit latches on event, holds until cleared
// - bit meaningful only when enabled in mask set; here status bits latch whatever the mask sets hold
// - all status bits reset to zero
// - status registers read-only; writes change nothing
// - acp content change sets 0x7a bit 5
// - vendor infoframe change sets 0x7a bit 4
// - mpeg source frame change sets 0x7a bit 3
// - product descriptor change sets 0x7a bit 2
// - audio infoframe change sets 0x7a bit 1
// - video infoframe change latched at 0x7a bit 0
// - audio buffer high mark sets 0x7f bit 7
// - audio buffer underflow sets 0x7f bit 6
// - audio buffer overflow sets 0x7f bit 5
// - cycle stamp drift sets 0x7f bit 4
// - regen divider change sets 0x7f bit 3
// - uncorrectable header error sets 0x7f bit 2
// - sound packet fault sets 0x7f bit 1
package paes_pkg;
  localparam int DATA_W = 8;
  // offsets other than 0x80 and 0x90 are not multiples of four: these are indices, byte address is index times four
  localparam logic [7:0] IDX_FRAME_STATUS = 8'h7a;
  localparam logic [7:0] IDX_AUDIO_STATUS = 8'h7f;
  localparam logic [7:0] IDX_FRAME_CLEAR = 8'h7b;
  localparam logic [7:0] IDX_AUDIO_CLEAR = 8'h80;
  localparam logic [7:0] IDX_MASK1_FRAME = 8'h90;
  localparam logic [7:0] IDX_MASK1_AUDIO = 8'h91;
  localparam logic [7:0] IDX_MASK2_FRAME = 8'h92;
  localparam logic [7:0] IDX_MASK2_AUDIO = 8'h93;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;
  // audio status bit 0 belongs to a neighbouring block and reads zero here
  localparam logic [7:0] AUDIO_IMPL = 8'hfe;
  localparam logic [7:0] FRAME_IMPL = 8'h3f;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } paes_apb_req_s;

  typedef struct packed {
    logic [DATA_W-1:0] frame;
    logic [DATA_W-1:0] audio;
  } paes_events_s;
endpackage

/* File: core/paes_event_status.sv */
// apb event status bank with two mask sets and two interrupt lines
`timescale 1ns/1ps
module paes_event_status (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic clkEn,
  input wire paes_pkg::paes_apb_req_s apbReq,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire paes_pkg::paes_events_s evtPulse,
  output logic firstIrq,
  output logic secondIrq
);
  // latched status words; bits outside the implemented masks stay zero
  logic [7:0] frameSt;
  logic [7:0] audioSt;
  // mask words of the first and second interrupt mask sets
  logic [7:0] m1Frame;
  logic [7:0] m1Audio;
  logic [7:0] m2Frame;
  logic [7:0] m2Audio;
  // values the state takes at the next enabled edge
  logic [7:0] next_frameSt;
  logic [7:0] next_audioSt;
  logic [7:0] next_m1Frame;
  logic [7:0] next_m1Audio;
  logic [7:0] next_m2Frame;
  logic [7:0] next_m2Audio;
  logic next_firstIrq;
  logic next_secondIrq;
  // per-bit set terms, already cut to the implemented bits
  logic [7:0] frameSet;
  logic [7:0] audioSet;
  // clear strobes, one bit per status bit
  logic [7:0] frameClr;
  logic [7:0] audioClr;
  // bus decode and read selection
  logic [9:0] wordIdx;
  logic lowPage;
  logic access;
  logic wrAcc;
  logic known;
  logic hitFrameSt;
  logic hitAudioSt;
  logic hitFrameClr;
  logic hitAudioClr;
  logic hitM1Frame;
  logic hitM1Audio;
  logic hitM2Frame;
  logic hitM2Audio;
  logic [7:0] rdWord;

  // access starts the answer; a write lands at the edge where the master sees pready high
  // limitation: clkEn must stay high through a transfer, a frozen edge would drop the write
  assign access = apbReq.psel && apbReq.penable && !pready;
  assign wrAcc = apbReq.psel && apbReq.penable && pready && apbReq.pwrite;
  assign wordIdx = apbReq.paddr[11:2];
  assign lowPage = (wordIdx[9:8] == 2'b00);

  // word decode; any hit needs the upper index bits at zero
  assign hitFrameSt = lowPage && (wordIdx[7:0] == paes_pkg::IDX_FRAME_STATUS);
  assign hitAudioSt = lowPage && (wordIdx[7:0] == paes_pkg::IDX_AUDIO_STATUS);
  assign hitFrameClr = lowPage && (wordIdx[7:0] == paes_pkg::IDX_FRAME_CLEAR);
  assign hitAudioClr = lowPage && (wordIdx[7:0] == paes_pkg::IDX_AUDIO_CLEAR);
  assign hitM1Frame = lowPage && (wordIdx[7:0] == paes_pkg::IDX_MASK1_FRAME);
  assign hitM1Audio = lowPage && (wordIdx[7:0] == paes_pkg::IDX_MASK1_AUDIO);
  assign hitM2Frame = lowPage && (wordIdx[7:0] == paes_pkg::IDX_MASK2_FRAME);
  assign hitM2Audio = lowPage && (wordIdx[7:0] == paes_pkg::IDX_MASK2_AUDIO);
  assign known = hitFrameSt || hitAudioSt || hitFrameClr || hitAudioClr ||
                 hitM1Frame || hitM1Audio || hitM2Frame || hitM2Audio;

  // a write of ones to a clear word clears those bits; the status words take no writes
  assign frameClr = (wrAcc && hitFrameClr) ? apbReq.pwdata[7:0] : 8'h00;
  assign audioClr = (wrAcc && hitAudioClr) ? apbReq.pwdata[7:0] : 8'h00;

  // one slice per bit: set beats clear, so an event during the clearing write is kept
  for (genvar b = 0; b < 8; b++) begin : g_bit
    assign frameSet[b] = evtPulse.frame[b] && paes_pkg::FRAME_IMPL[b];
    assign audioSet[b] = evtPulse.audio[b] && paes_pkg::AUDIO_IMPL[b];
    assign next_frameSt[b] = (frameSt[b] && !frameClr[b]) || frameSet[b];
    assign next_audioSt[b] = (audioSt[b] && !audioClr[b]) || audioSet[b];
    // unused bit positions get a tie-to-zero check instead of the event checks
    if (paes_pkg::FRAME_IMPL[b]) begin : g_frame
      AST_FRAME_SET: assert property (@(posedge clk_sys) disable iff (srst)
        clkEn && evtPulse.frame[b] |=> frameSt[b])
        else $error("frame event not latched");
      AST_FRAME_CLR: assert property (@(posedge clk_sys) disable iff (srst)
        clkEn && frameClr[b] && !evtPulse.frame[b] |=> !frameSt[b])
        else $error("frame bit not cleared");
      AST_FRAME_KEEP: assert property (@(posedge clk_sys) disable iff (srst)
        clkEn && frameSt[b] && !frameClr[b] |=> frameSt[b])
        else $error("frame bit dropped without clear");
      AST_FRAME_QUIET: assert property (@(posedge clk_sys) disable iff (srst)
        clkEn && !frameSt[b] && !evtPulse.frame[b] |=> !frameSt[b])
        else $error("frame bit rose without event");
    end else begin : g_frame_none
      AST_FRAME_ZERO: assert property (@(posedge clk_sys) disable iff (srst)
        frameSt[b] == 1'b0)
        else $error("unused frame bit set");
    end
    if (paes_pkg::AUDIO_IMPL[b]) begin : g_audio
      AST_AUDIO_SET: assert property (@(posedge clk_sys) disable iff (srst)
        clkEn && evtPulse.audio[b] |=> audioSt[b])
        else $error("audio event not latched");
      AST_AUDIO_CLR: assert property (@(posedge clk_sys) disable iff (srst)
        clkEn && audioClr[b] && !evtPulse.audio[b] |=> !audioSt[b])
        else $error("audio bit not cleared");
      AST_AUDIO_KEEP: assert property (@(posedge clk_sys) disable iff (srst)
        clkEn && audioSt[b] && !audioClr[b] |=> audioSt[b])
        else $error("audio bit dropped without clear");
      AST_AUDIO_QUIET: assert property (@(posedge clk_sys) disable iff (srst)
        clkEn && !audioSt[b] && !evtPulse.audio[b] |=> !audioSt[b])
        else $error("audio bit rose without event");
    end else begin : g_audio_none
      AST_AUDIO_ZERO: assert property (@(posedge clk_sys) disable iff (srst)
        audioSt[b] == 1'b0)
        else $error("unused audio bit set");
    end
  end

  // mask words change only at the completing edge of a write aimed at them
  always_comb begin
    next_m1Frame = m1Frame;
    next_m1Audio = m1Audio;
    next_m2Frame = m2Frame;
    next_m2Audio = m2Audio;
    if (wrAcc && hitM1Frame) begin
      next_m1Frame = apbReq.pwdata[7:0];
    end
    if (wrAcc && hitM1Audio) begin
      next_m1Audio = apbReq.pwdata[7:0];
    end
    if (wrAcc && hitM2Frame) begin
      next_m2Frame = apbReq.pwdata[7:0];
    end
    if (wrAcc && hitM2Audio) begin
      next_m2Audio = apbReq.pwdata[7:0];
    end
  end

  // next-state terms on both sides, so a mask write with status set shows without lag
  always_comb begin
    next_firstIrq = (|(next_frameSt & next_m1Frame)) || (|(next_audioSt & next_m1Audio));
    next_secondIrq = (|(next_frameSt & next_m2Frame)) || (|(next_audioSt & next_m2Audio));
  end

  // read selection; the clear words and unmapped words read back as zero
  always_comb begin
    rdWord = 8'h00;
    if (hitFrameSt) begin
      rdWord = frameSt;
    end else if (hitAudioSt) begin
      rdWord = audioSt;
    end else if (hitM1Frame) begin
      rdWord = m1Frame;
    end else if (hitM1Audio) begin
      rdWord = m1Audio;
    end else if (hitM2Frame) begin
      rdWord = m2Frame;
    end else if (hitM2Audio) begin
      rdWord = m2Audio;
    end
  end

  // status bits: reset wipes them, clkEn low freezes them, bus writes reach them only through the clear words
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      frameSt <= paes_pkg::STATUS_RESET;
      audioSt <= paes_pkg::STATUS_RESET;
    end else if (clkEn) begin
      frameSt <= next_frameSt;
      audioSt <= next_audioSt;
    end
  end

  // mask sets reset to zero so no line rises before software opts in
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      m1Frame <= paes_pkg::MASK_RESET;
      m1Audio <= paes_pkg::MASK_RESET;
      m2Frame <= paes_pkg::MASK_RESET;
      m2Audio <= paes_pkg::MASK_RESET;
    end else if (clkEn) begin
      m1Frame <= next_m1Frame;
      m1Audio <= next_m1Audio;
      m2Frame <= next_m2Frame;
      m2Audio <= next_m2Audio;
    end
  end

  // each mask set steers its own interrupt line
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      firstIrq <= 1'b0;
      secondIrq <= 1'b0;
    end else if (clkEn) begin
      firstIrq <= next_firstIrq;
      secondIrq <= next_secondIrq;
    end
  end

  // apb answer: one wait state, pready for one cycle, unmapped words give slverr and zero
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (clkEn) begin
      pready <= access;
      pslverr <= access && !known;
      prdata <= (access && !apbReq.pwrite && known) ? {24'h000000, rdWord} : 32'h0000_0000;
    end
  end

  // latching and clearing of single bits
  AST_HOLD: assert property (@(posedge clk_sys) disable iff (srst)
    clkEn && frameSt[5] && !frameClr[5] |=> frameSt[5])
    else $error("status bit dropped without clear");

  AST_SET: assert property (@(posedge clk_sys) disable iff (srst)
    clkEn && evtPulse.frame[5] |=> frameSt[5])
    else $error("acp event not latched");

  AST_SETWINS: assert property (@(posedge clk_sys) disable iff (srst)
    clkEn && audioClr[3] && evtPulse.audio[3] |=> audioSt[3])
    else $error("event lost on clear");

  AST_CLEAR: assert property (@(posedge clk_sys) disable iff (srst)
    clkEn && frameClr[1] && !evtPulse.frame[1] |=> !frameSt[1])
    else $error("clear ignored");

  AST_RO: assert property (@(posedge clk_sys) disable iff (srst)
    clkEn && wrAcc && wordIdx[7:0] == paes_pkg::IDX_AUDIO_STATUS && evtPulse.audio == 8'h00
    |=> audioSt == $past(audioSt)) else $error("status changed by write");

  // every event source lands on its own bit
  AST_VENDOR_SET: assert property (@(posedge clk_sys) disable iff (srst)
    clkEn && evtPulse.frame[4] |=> frameSt[4])
    else $error("vendor frame event not latched");

  AST_MPEG_SET: assert property (@(posedge clk_sys) disable iff (srst)
    clkEn && evtPulse.frame[3] |=> frameSt[3])
    else $error("source frame event not latched");

  AST_PRODUCT_SET: assert property (@(posedge clk_sys) disable iff (srst)
    clkEn && evtPulse.frame[2] |=> frameSt[2])
    else $error("product frame event not latched");

  AST_AUDIOINFO_SET: assert property (@(posedge clk_sys) disable iff (srst)
    clkEn && evtPulse.frame[1] |=> frameSt[1])
    else $error("audio frame event not latched");

  AST_VIDEO_SET: assert property (@(posedge clk_sys) disable iff (srst)
    clkEn && evtPulse.frame[0] |=> frameSt[0])
    else $error("video frame event not latched");

  AST_HIGHMARK_SET: assert property (@(posedge clk_sys) disable iff (srst)
    clkEn && evtPulse.audio[7] |=> audioSt[7])
    else $error("high mark event not latched");

  AST_EMPTY_SET: assert property (@(posedge clk_sys) disable iff (srst)
    clkEn && evtPulse.audio[6] |=> audioSt[6])
    else $error("underflow event not latched");

  AST_OVF: assert property (@(posedge clk_sys) disable iff (srst)
    clkEn && evtPulse.audio[5] |=> audioSt[5] [*2] or (audioSt[5] ##1 1'b1))
    else $error("overflow not latched");

  AST_DRIFT_SET: assert property (@(posedge clk_sys) disable iff (srst)
    clkEn && evtPulse.audio[4] |=> audioSt[4])
    else $error("drift event not latched");

  AST_DIVIDER_SET: assert property (@(posedge clk_sys) disable iff (srst)
    clkEn && evtPulse.audio[3] |=> audioSt[3])
    else $error("divider event not latched");

  AST_HEADER_SET: assert property (@(posedge clk_sys) disable iff (srst)
    clkEn && evtPulse.audio[2] |=> audioSt[2])
    else $error("header error event not latched");

  AST_SOUND_SET: assert property (@(posedge clk_sys) disable iff (srst)
    clkEn && evtPulse.audio[1] |=> audioSt[1])
    else $error("sound packet event not latched");

  // interrupt lines, reset and freeze
  AST_IRQ: assert property (@(posedge clk_sys) disable iff (srst)
    clkEn |=> firstIrq == (|(frameSt & m1Frame) || |(audioSt & m1Audio)))
    else $error("first irq missing");

  AST_IRQ2: assert property (@(posedge clk_sys) disable iff (srst)
    clkEn |=> secondIrq == (|(frameSt & m2Frame) || |(audioSt & m2Audio)))
    else $error("second irq wrong");

  AST_RESET: assert property (@(posedge clk_sys)
    srst |=> frameSt == 8'h00 && audioSt == 8'h00)
    else $error("status not zero after reset");

  AST_RESET_OUT: assert property (@(posedge clk_sys)
    srst |=> !firstIrq && !secondIrq && !pready && !pslverr)
    else $error("outputs not idle after reset");

  AST_FREEZE: assert property (@(posedge clk_sys) disable iff (srst)
    !clkEn |=> frameSt == $past(frameSt) && audioSt == $past(audioSt))
    else $error("status moved while frozen");

  // bus answer
  AST_READY: assert property (@(posedge clk_sys) disable iff (srst)
    clkEn && access |=> pready ##1 !pready || !clkEn)
    else $error("pready not single cycle");

  AST_SLVERR: assert property (@(posedge clk_sys) disable iff (srst)
    pslverr |-> pready)
    else $error("slverr without pready");

  AST_RDZERO: assert property (@(posedge clk_sys) disable iff (srst)
    !pready |-> prdata == 32'h0000_0000)
    else $error("read data outside answer");

  AST_RD_FRAME: assert property (@(posedge clk_sys) disable iff (srst)
    clkEn && access && !apbReq.pwrite && hitFrameSt |=> prdata == {24'h000000, $past(frameSt)})
    else $error("frame status read wrong");

  AST_RD_AUDIO: assert property (@(posedge clk_sys) disable iff (srst)
    clkEn && access && !apbReq.pwrite && hitAudioSt |=> prdata == {24'h000000, $past(audioSt)})
    else $error("audio status read wrong");

  AST_RD_CLEAR: assert property (@(posedge clk_sys) disable iff (srst)
    clkEn && access && !apbReq.pwrite && hitFrameClr |=> prdata == 32'h0000_0000)
    else $error("clear word read not zero");
endmodule

/* File: test/tb_paes_event_status.sv */
// self-checking bench for the packet and audio event status bank
`timescale 1ns/1ps
module tb_paes_event_status;
  logic clk_sys, srst, clkEn, pready, pslverr, firstIrq, secondIrq, err;
  paes_pkg::paes_apb_req_s apbReq;
  paes_pkg::paes_events_s evtPulse;
  logic [31:0] prdata, rd;
  int failures, cmp_count;

  paes_event_status dut_u (.clk_sys(clk_sys), .srst(srst), .clkEn(clkEn), .apbReq(apbReq), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .evtPulse(evtPulse), .firstIrq(firstIrq), .secondIrq(secondIrq));

  // 100 MHz core clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one apb transfer; pready is read right after the edge, so it is the value sampled there
  // ea holds audio events through the access phase; only the watchdog ends a wait
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd, input logic [7:0] ea = 8'h00);
    @(posedge clk_sys);
    apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: {2'h0, idx, 2'h0}, pwdata: wd};
    @(posedge clk_sys);
    apbReq.penable <= 1'b1;
    evtPulse.audio <= ea;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    apbReq.psel <= 1'b0;
    apbReq.penable <= 1'b0;
    evtPulse.audio <= 8'h00;
  endtask

  // one-cycle event pulse
  task automatic pulse(input logic [7:0] f, input logic [7:0] a);
    @(posedge clk_sys);
    evtPulse <= '{frame: f, audio: a};
    @(posedge clk_sys);
    evtPulse <= '0;
  endtask

  task automatic conclude;
    $display("comparisons=%0d failures=%0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // hang guard: the sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk_sys);
    failures++;
    conclude();
  end

  // main sequence
  initial begin
    logic [7:0] m, st, cl;
    logic fr;
    srst = 1'b1; clkEn = 1'b1; apbReq = '0; evtPulse = '0; failures = 0; cmp_count = 0;
    repeat (5) @(posedge clk_sys);
    srst <= 1'b0;
    apb(0, paes_pkg::IDX_FRAME_STATUS, 0); chk(rd, 32'h0);
    apb(0, paes_pkg::IDX_AUDIO_STATUS, 0); chk(rd, 32'h0);
    chk({30'h0, firstIrq, secondIrq}, 32'h0);
    apb(0, 8'h00, 0); chk({err, rd[30:0]}, 32'h80000000);
    // walk every implemented bit: set, hold through reads and writes, clear
    for (int i = 0; i < 13; i++) begin
      fr = (i < 6);
      m = fr ? 8'h01 << i : 8'h01 << (i - 5);
      st = fr ? paes_pkg::IDX_FRAME_STATUS : paes_pkg::IDX_AUDIO_STATUS;
      cl = fr ? paes_pkg::IDX_FRAME_CLEAR : paes_pkg::IDX_AUDIO_CLEAR;
      pulse(fr ? m : 8'h00, fr ? 8'h00 : m);
      apb(0, st, 0); chk(rd, {24'h0, m});
      apb(1, st, 32'hff); apb(0, st, 0); chk(rd, {24'h0, m});
      apb(1, cl, {24'h0, m}); apb(0, st, 0); chk(rd, 32'h0);
    end
    // each mask set gates its own interrupt line
    apb(1, paes_pkg::IDX_MASK1_FRAME, 32'h20); apb(1, paes_pkg::IDX_MASK2_AUDIO, 32'h02);
    apb(0, paes_pkg::IDX_MASK1_FRAME, 0); chk(rd, 32'h20);
    pulse(8'h20, 8'h00); @(posedge clk_sys); chk({30'h0, firstIrq, secondIrq}, 32'h2);
    pulse(8'h00, 8'h02); @(posedge clk_sys); chk({30'h0, firstIrq, secondIrq}, 32'h3);
    apb(1, paes_pkg::IDX_FRAME_CLEAR, 32'h20); apb(1, paes_pkg::IDX_AUDIO_CLEAR, 32'h02);
    pulse(8'h00, 8'h80); @(posedge clk_sys); chk({30'h0, firstIrq, secondIrq}, 32'h0);
    apb(0, paes_pkg::IDX_AUDIO_STATUS, 0); chk(rd, 32'h80);
    // clear word reads zero; an event during the clearing write survives it
    apb(0, paes_pkg::IDX_FRAME_CLEAR, 0); chk(rd, 32'h0);
    pulse(8'h00, 8'h08); apb(1, paes_pkg::IDX_AUDIO_CLEAR, 32'h08, 8'h08);
    apb(0, paes_pkg::IDX_AUDIO_STATUS, 0); chk(rd, 32'h88);
    apb(1, paes_pkg::IDX_AUDIO_CLEAR, 32'h08); apb(0, paes_pkg::IDX_AUDIO_STATUS, 0); chk(rd, 32'h80);
    // clkEn low freezes the status bits against events
    @(posedge clk_sys); clkEn <= 1'b0;
    pulse(8'h01, 8'h00); clkEn <= 1'b1;
    apb(0, paes_pkg::IDX_FRAME_STATUS, 0); chk(rd, 32'h0);
    // second reset with state held must wipe status and masks
    @(posedge clk_sys); srst <= 1'b1;
    repeat (2) @(posedge clk_sys); srst <= 1'b0;
    apb(0, paes_pkg::IDX_AUDIO_STATUS, 0); chk(rd, 32'h0);
    apb(0, paes_pkg::IDX_MASK1_FRAME, 0); chk(rd, 32'h0);
    conclude();
  end
endmodule
